// ===== src/frcdt_consts.vh
`ifndef FRCDT_CONSTS_VH
`define FRCDT_CONSTS_VH
// Register offsets
`define FRCDT_OFS_TRIM 8'h83
`define FRCDT_OFS_OPT0 8'hc1
`define FRCDT_OFS_STAT 8'hd0
`define FRCDT_OFS_TICK 8'hd1
// Option word zero field positions
`define FRCDT_DIV_LSB 4
`define FRCDT_DIV_MSB 5
// Divide select codes and ratios minus one
`define FRCDT_DIV_1 2'h0
`define FRCDT_DIV_2 2'h1
`define FRCDT_DIV_4 2'h2
`define FRCDT_DIV_12 2'h3
`define FRCDT_RATIO_1 4'h0
`define FRCDT_RATIO_2 4'h1
`define FRCDT_RATIO_4 4'h3
`define FRCDT_RATIO_12 4'hb
// Trim step in hundredths of a percent per unit
`define FRCDT_TRIM_STEP_CPCT 16'h0017
// Nominal oscillator rate and safe limit in kHz
`define FRCDT_OSC_NOM_KHZ 32'h00005dc0
`define FRCDT_SYS_MAX_KHZ 32'h00005dc0
// Reset values
`define FRCDT_TRIM_RST 8'h80
`define FRCDT_OPT0_RST 8'h00
`endif

// ===== src/frcdt_divider.v
`timescale 1ns/10ps
`default_nettype none
module frcdt_divider (
    input wire clk_in,
    input wire rst_n_in,
    input wire [3:0] ratio_m1_in,
    output reg tick_out
);
    reg [3:0] cnt_r;
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            cnt_r <= 4'h0;
            tick_out <= 1'b0;
        end else if (cnt_r >= ratio_m1_in) begin
            // Greater-or-equal so a smaller ratio never strands the count
            cnt_r <= 4'h0;
            tick_out <= 1'b1;
        end else begin
            cnt_r <= cnt_r + 4'h1;
            tick_out <= 1'b0;
        end
    end
endmodule // frcdt_divider
`default_nettype wire

// ===== src/frcdt_top.v
// Functional notes
// - System clock from fast oscillator, four rates
// - Divide select: 00/1, 01/2, 10/4, 11/12
// - Trim register 8 bit, read/write at 83h
// - Trim loads calibrated value at power-on
// - Each trim unit shifts frequency 0.23 percent
//
// The plain strobed port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
`include "frcdt_consts.vh"
module frcdt_top #(
    parameter [7:0] CAL_TRIM = `FRCDT_TRIM_RST,
    parameter [7:0] OPT0_FACTORY = `FRCDT_OPT0_RST
) (
    input wire clk_in,
    input wire rst_n_in,
    input wire [7:0] addr_in,
    input wire [7:0] wdata_in,
    input wire wr_in,
    input wire rd_in,
    output reg [7:0] rdata_out,
    output reg [7:0] osc_trim_value_out,
    output reg [1:0] sysclk_div_sel_out,
    output reg signed [15:0] trim_offset_cpct_out,
    output reg [31:0] sysclk_khz_out,
    output reg over_limit_out,
    output wire sysclk_tick_out
);
    // Address decode, one compare per mapped location
    wire hit_trim;
    wire hit_opt0;
    wire hit_stat;
    wire hit_tick;

    // Qualified strobes
    wire wr_trim;
    wire wr_opt0;
    wire rd_trim;
    wire rd_opt0;
    wire rd_stat;
    wire rd_tick;

    // Option word and trim storage
    reg [7:0] opt0_r;
    reg [7:0] opt0_nxt;
    reg [7:0] trim_nxt;

    // Divide select and ratio
    wire [1:0] div_code;
    reg [3:0] ratio_m1;

    // Software view of sysclk ticks
    reg [7:0] tick_cnt_r;
    reg [7:0] tick_cnt_nxt;

    // Frequency model terms
    wire signed [8:0] trim_ext;
    wire signed [8:0] cal_ext;
    reg signed [8:0] delta;
    wire [15:0] delta_ext;
    reg signed [47:0] osc_khz_x;
    reg [31:0] osc_khz;
    wire [31:0] sys_khz_by_code [0:3];
    reg [31:0] sys_khz;

    // Next values of the registered outputs
    reg [1:0] div_sel_nxt;
    reg signed [15:0] offset_nxt;
    reg [31:0] khz_nxt;
    reg over_nxt;
    reg [7:0] rdata_nxt;
    wire [7:0] stat_word;

    genvar gb;
    genvar gc;

    assign hit_trim = (addr_in == `FRCDT_OFS_TRIM);
    assign hit_opt0 = (addr_in == `FRCDT_OFS_OPT0);
    assign hit_stat = (addr_in == `FRCDT_OFS_STAT);
    assign hit_tick = (addr_in == `FRCDT_OFS_TICK);

    // Status and tick locations are read only; writes there are dropped
    assign wr_trim = wr_in & hit_trim;
    assign wr_opt0 = wr_in & hit_opt0;
    assign rd_trim = rd_in & hit_trim;
    assign rd_opt0 = rd_in & hit_opt0;
    assign rd_stat = rd_in & hit_stat;
    assign rd_tick = rd_in & hit_tick;

    // Trim loads at power-on; writes hold until rewritten
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            osc_trim_value_out <= CAL_TRIM;
        end else begin
            osc_trim_value_out <= trim_nxt;
        end
    end

    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            opt0_r <= OPT0_FACTORY;
        end else begin
            opt0_r <= opt0_nxt;
        end
    end

    always @* begin
        trim_nxt = osc_trim_value_out;
        if (wr_trim) begin
            trim_nxt = wdata_in;
        end
    end

    // Trim writes never touch the option word or the divider
    always @* begin
        opt0_nxt = opt0_r;
        if (wr_opt0) begin
            opt0_nxt = wdata_in;
        end
    end

    assign div_code = opt0_r[`FRCDT_DIV_MSB:`FRCDT_DIV_LSB];

    always @* begin
        case (div_code)
            `FRCDT_DIV_1: begin
                ratio_m1 = `FRCDT_RATIO_1;
            end
            `FRCDT_DIV_2: begin
                ratio_m1 = `FRCDT_RATIO_2;
            end
            `FRCDT_DIV_4: begin
                ratio_m1 = `FRCDT_RATIO_4;
            end
            `FRCDT_DIV_12: begin
                ratio_m1 = `FRCDT_RATIO_12;
            end
            default: begin
                ratio_m1 = `FRCDT_RATIO_1;
            end
        endcase
    end

    // Oscillator model is linear; drift is not represented
    assign trim_ext = $signed({1'b0, osc_trim_value_out});
    assign cal_ext = $signed({1'b0, CAL_TRIM});

    always @* begin
        delta = trim_ext - cal_ext;
    end

    // Sign extension of the trim offset, one bit per stage
    generate
        for (gb = 0; gb < 16; gb = gb + 1) begin : g_sext
            if (gb < 9) begin : g_low
                assign delta_ext[gb] = delta[gb];
            end else begin : g_high
                assign delta_ext[gb] = delta[8];
            end
        end
    endgenerate

    always @* begin
        osc_khz_x = $signed({16'h0000, `FRCDT_OSC_NOM_KHZ})
            * (48'sd10000 + $signed(delta) * $signed({1'b0, `FRCDT_TRIM_STEP_CPCT}));
        // Full trim range stays inside 32 bits, so the upper part is dropped
        osc_khz = osc_khz_x[31:0] / 32'd10000;
    end

    // One quotient per code; area traded for a short select path
    generate
        for (gc = 0; gc < 4; gc = gc + 1) begin : g_code
            localparam [3:0] RM1 = (gc == 0) ? `FRCDT_RATIO_1 :
                (gc == 1) ? `FRCDT_RATIO_2 :
                (gc == 2) ? `FRCDT_RATIO_4 : `FRCDT_RATIO_12;
            assign sys_khz_by_code[gc] = osc_khz / ({28'h0, RM1} + 32'h1);
        end
    endgenerate

    always @* begin
        sys_khz = sys_khz_by_code[div_code];
    end

    always @* begin
        div_sel_nxt = div_code;
        offset_nxt = $signed(delta_ext) * $signed(`FRCDT_TRIM_STEP_CPCT);
        khz_nxt = sys_khz;
        // Software must respect the limit; hardware only flags it
        over_nxt = (sys_khz > `FRCDT_SYS_MAX_KHZ);
    end

    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            sysclk_div_sel_out <= 2'h0;
        end else begin
            sysclk_div_sel_out <= div_sel_nxt;
        end
    end

    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            trim_offset_cpct_out <= 16'sh0000;
        end else begin
            trim_offset_cpct_out <= offset_nxt;
        end
    end

    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            sysclk_khz_out <= 32'h0;
        end else begin
            sysclk_khz_out <= khz_nxt;
        end
    end

    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            over_limit_out <= 1'b0;
        end else begin
            over_limit_out <= over_nxt;
        end
    end

    frcdt_divider u_div (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .ratio_m1_in(ratio_m1),
        .tick_out(sysclk_tick_out)
    );

    always @* begin
        tick_cnt_nxt = tick_cnt_r;
        if (sysclk_tick_out) begin
            // Wraps at 8 bits; software takes differences
            tick_cnt_nxt = tick_cnt_r + 8'h01;
        end
    end

    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            tick_cnt_r <= 8'h00;
        end else begin
            tick_cnt_r <= tick_cnt_nxt;
        end
    end

    assign stat_word = {5'h00, over_limit_out, sysclk_div_sel_out};

    // Read data one cycle after the strobe; otherwise the bus reads zero
    always @* begin
        rdata_nxt = 8'h00;
        if (rd_trim) begin
            rdata_nxt = osc_trim_value_out;
        end
        if (rd_opt0) begin
            rdata_nxt = opt0_r;
        end
        if (rd_stat) begin
            rdata_nxt = stat_word;
        end
        if (rd_tick) begin
            rdata_nxt = tick_cnt_r;
        end
    end

    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            rdata_out <= 8'h00;
        end else begin
            rdata_out <= rdata_nxt;
        end
    end

endmodule // frcdt_top
`default_nettype wire

// ===== tb/frcdt_sva.sv
`timescale 1ns/10ps
`default_nettype none
module frcdt_sva #(parameter [7:0] CAL_TRIM = 8'h80) (
    input wire clk_in,
    input wire rst_n_in,
    input wire [7:0] addr_in,
    input wire [7:0] wdata_in,
    input wire wr_in,
    input wire rd_in,
    input wire [7:0] rdata_out,
    input wire [7:0] osc_trim_value_out,
    input wire [1:0] sysclk_div_sel_out,
    input wire signed [15:0] trim_offset_cpct_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    chk_trim_read: assert property (rd_in && addr_in == 8'h83 |=>
        rdata_out == $past(osc_trim_value_out)) else $error("trim read");
    chk_trim_write: assert property (wr_in && addr_in == 8'h83 |=>
        osc_trim_value_out == $past(wdata_in)) else $error("trim write");
    chk_trim_hold: assert property (!(wr_in && addr_in == 8'h83) |=>
        $stable(osc_trim_value_out)) else $error("trim hold");
    chk_trim_cal: assert property ($rose(rst_n_in) |->
        osc_trim_value_out == CAL_TRIM) else $error("trim cal");
    chk_trim_step: assert property (trim_offset_cpct_out ==
        ({8'h00, $past(osc_trim_value_out)} - {8'h00, CAL_TRIM}) * 16'h0017) else $error("step");
    chk_div_follow: assert property (wr_in && addr_in == 8'hc1 |=> ##1
        {2'b00, sysclk_div_sel_out, 4'h0} == ($past(wdata_in, 2) & 8'h30)) else $error("div");
endmodule // frcdt_sva
bind frcdt_top frcdt_sva #(.CAL_TRIM(CAL_TRIM)) u_sva (.*);
`default_nettype wire

// ===== tb/tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin error_cnt++; \
    $display("unexpected %0t %h %h", $time, a, b); end end
module tb;
    logic clk_in = 0, rst_n_in = 0, wr_in = 0, rd_in = 0, over_limit_out, sysclk_tick_out;
    logic [7:0] addr_in = 0, wdata_in = 0, rdata_out, osc_trim_value_out, d, exp_q[$];
    logic [1:0] sysclk_div_sel_out;
    logic signed [15:0] trim_offset_cpct_out;
    logic [31:0] sysclk_khz_out;
    int error_cnt = 0, n_compared = 0, seed = 9, n, i, pend = 0, rat[4] = '{1, 2, 4, 12};
    always #20 clk_in = ~clk_in;
    frcdt_top #(.CAL_TRIM(8'h5a)) u_dut (.*);
    task bus(input logic w, r, input logic [7:0] a, v);
        @(posedge clk_in);
        {wr_in, rd_in, addr_in, wdata_in} <= {w, r, a, v};
    endtask
    task finish_test;
        $display("compared %0d errors %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Read data stand one cycle only, so look mid-cycle
    always @(negedge clk_in) begin
        if (pend) `CHK(rdata_out, exp_q[0])
        if (pend) exp_q.delete(0);
        pend = rd_in;
    end
    initial begin
        repeat (4) @(posedge clk_in);
        rst_n_in <= 1;
        exp_q.push_back(8'h5a);
        bus(0, 1, 8'h83, 8'h00);
        for (i = 0; i < 4; i++) begin
            bus(1, 0, 8'hc1, 8'(i << 4));
            bus(1, 0, 8'h83, 8'h5a);
            bus(0, 0, 8'h00, 8'h00);
            repeat (16) @(negedge clk_in);
            n = 0;
            repeat (24) @(negedge clk_in) n += sysclk_tick_out;
            `CHK(sysclk_div_sel_out, 2'(i))
            `CHK(n, 24 / rat[i])
            `CHK(sysclk_khz_out, 32'h00005dc0 / rat[i])
            exp_q.push_back(8'(i));
            bus(0, 1, 8'hd0, 8'h00);
            d = 8'($random(seed));
            if (i == 0) d = d & 8'h3f;
            exp_q.push_back(d);
            bus(1, 0, 8'h83, d);
            bus(0, 1, 8'h83, 8'h00);
            bus(0, 0, 8'h00, 8'h00);
            repeat (3) @(negedge clk_in);
            `CHK(trim_offset_cpct_out, ({8'h00, d} - 16'h005a) * 16'h0017)
            `CHK(sysclk_khz_out, 32'((24000 * (10000 + (int'(d) - 90) * 23) / 10000) / rat[i]))
            `CHK(over_limit_out, 1'b0)
        end
        finish_test;
    end
endmodule // tb
`default_nettype wire
